// file: design/edge_sync.sv
// Three-stage synchroniser with a stable-change filter and edge outputs.
// Assumes din may change at any time relative to clk.
module edge_sync (
   input  wire logic clk,      // System clock
   input  wire logic rstn,     // Async reset, active low
   input  wire logic din,      // Asynchronous input
   output logic      level,    // Filtered level
   output logic      rise,     // One-cycle pulse on rising change
   output logic      fall      // One-cycle pulse on falling change
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lv;
   } state_t;
   state_t q;
   state_t d;

   // Second and third stages must agree before the level moves
   always_comb begin
      d    = q;
      d.s1 = din;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 == q.s3) begin
         d.lv = q.s3;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign level = q.lv;
   assign rise  = d.lv & ~q.lv;
   assign fall  = ~d.lv & q.lv;
endmodule

// file: design/tv_input_pkg.sv
// Constants shared by the video input front end of the TV encoder.
// Assumes a 40 MHz system clock ref_clk and asynchronously sampled pixel pins.
package tv_input_pkg;
   // Register byte offsets on the AHB-Lite bus
   localparam logic [7:0]  CTRL_OFS        = 8'h00;
   localparam logic [7:0]  REFCLK_OFS      = 8'h04;
   localparam logic [7:0]  STATUS_OFS      = 8'h08;
   localparam logic [7:0]  WIDTH_OFS       = 8'h0C;
   localparam logic [7:0]  PIXEL_OFS       = 8'h10;
   localparam logic [7:0]  SYNCGEN_OFS     = 8'h14;
   // Control field positions
   localparam int          SYNC_DIR_BIT    = 0;
   localparam int          MASTER_BIT      = 1;
   localparam int          REFCLK_HIZ_BIT  = 2;
   localparam int          MUX_BIT         = 3;
   localparam int          CLK2X_BIT       = 4;
   localparam int          CLK_INV_BIT     = 5;
   localparam int          INTERLACE_BIT   = 6;
   localparam int          SINGLE_CVBS_BIT = 7;
   localparam int          SOFT_RESET_BIT  = 8;
   localparam int          PAL_BIT         = 9;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
   // Reference clock divider reset value: 40 MHz / (2*4) = 5 MHz
   localparam logic [7:0]  REFDIV_RESET    = 8'h04;
   // Serial port addresses selected by the address strap
   localparam logic [6:0]  ADDR_HIGH       = 7'h75;
   localparam logic [6:0]  ADDR_LOW        = 7'h76;
   // Line timing: 63.5 us line, nominal 64-clock sync width
   localparam int          REF_CLK_MHZ     = 40;
   localparam real         LINE_US         = 63.5;
   localparam int          LINE_CYC        = int'(LINE_US * REF_CLK_MHZ);
   localparam int          HALF_LINE_CYC   = LINE_CYC / 2;
   localparam logic [11:0] HSYNC_W_RESET   = 12'h040;
   localparam logic [11:0] LINES_PER_FIELD = 12'h106;
   localparam logic [11:0] VSYNC_LINES     = 12'h003;
   // Input scaler range limits
   localparam logic [11:0] MIN_WIDTH       = 12'h0DC;
   localparam logic [11:0] MAX_WIDTH       = 12'h2D0;
   localparam logic [11:0] MIN_LINES       = 12'h0B0;
   localparam logic [11:0] MAX_LINES       = 12'h240;
endpackage

// file: design/tv_video_input.sv
// Pixel input front end of the TV encoder: capture, sync handling, reference clock.
// Assumes pixel pins arrive asynchronous to ref_clk (pixel clock is sampled, not used
// as a clock) and an AHB-Lite master with single word transfers.
// Contract
// - Sync direction bit low takes H/V as inputs, high drives them out.
// - Source drives data valid; high means active pixels, low blanking.
// - Address strap high gives 75h, otherwise 76h; default low.
// - Reset pin low holds reset; high leaves reset to software control.
// - Single composite mode turns the secondary video output off.
// - Software control places the reference clock output in high impedance.
// - Master mode drives a programmable reference clock, 2.3 to 64 MHz; here 40 MHz / (2*refDiv), at most 20 MHz.
// - Slave mode outputs no reference clock.
// - Sync comes from pins, embedded codes, or is driven by the device; embedded codes are not decoded here.
// - Data unitary or 2X multiplexed; clock 1X or 2X pixel rate.
// - Non-interlaced input is scaled; widths 220 to 720, lines 176 to 576.
// - Interlaced input bypasses scaling; 480i NTSC and 576i PAL.
// - Driven field 1 vsync aligns hsync; field 2 delayed half a line.
// - Line 63.5 us; hsync width at least one, typically 64 clocks.
// - Hsync, vsync, data valid and pixel bus captured on pixel clock; here hsync and vsync are sampled on ref_clk instead.
// - Field identity derived from incoming vsync to hsync alignment.
// - Multiplexed 1X clock latches both edges; otherwise one edge.
// - Software setting inverts capture clock polarity.
//
// Chosen here: the register addresses and the AHB-Lite register port.
module tv_video_input (
   input  wire logic        ref_clk,       // System clock, 40 MHz
   input  wire logic        rstn,          // Async reset, active low
   input  wire logic        resetPinN,     // Device reset pin, active low
   input  wire logic        busAddressSelect, // Serial address strap
   output logic [6:0]       serialAddress, // Selected 7-bit serial address
   input  wire logic        hsel,          // AHB-Lite select
   input  wire logic [31:0] haddr,         // AHB-Lite address
   input  wire logic [1:0]  htrans,        // AHB-Lite transfer type
   input  wire logic        hwrite,        // AHB-Lite write
   input  wire logic [2:0]  hsize,         // AHB-Lite size
   input  wire logic [31:0] hwdata,        // AHB-Lite write data
   input  wire logic        hready,        // AHB-Lite bus ready
   output logic [31:0]      hrdata,        // AHB-Lite read data
   output logic             hreadyout,     // AHB-Lite slave ready
   output logic             hresp,         // AHB-Lite response, always OKAY
   input  wire logic        pixelInputClock, // Pixel clock pin, sampled
   input  wire logic [23:0] pixelData,     // Pixel bus
   input  wire logic        dataValidStrobe, // Active-video strobe
   input  wire logic        hsyncIn,       // H sync pin input
   output logic             hsyncOut,      // H sync pin output
   output logic             hsyncOe,       // H sync pin drive enable
   input  wire logic        vsyncIn,       // V sync pin input
   output logic             vsyncOut,      // V sync pin output
   output logic             vsyncOe,       // V sync pin drive enable
   output logic             refClockOut,   // Reference clock to controller
   output logic             refClockOe,    // Reference clock drive enable
   output logic             secondaryVideoEn, // Secondary DAC enable
   output logic [23:0]      capturedPixel, // Last captured active pixel
   output logic             pixelValid,    // Pulse per captured pixel word
   output logic             bypassScaler,  // Scaler bypassed: interlaced or size out of range
   output logic             fieldTwo,      // Current field is field 2
   output logic             coreResetN     // Core reset, active low
);
   typedef struct packed {
      logic [31:0] ctrl;
      logic [7:0]  refDiv;
      logic [11:0] hsyncW;
      logic [7:0]  divCnt;
      logic        refClk;
      logic        aPend;
      logic        aWrite;
      logic [7:0]  aAddr;
      logic [23:0] pixel;
      logic        pixValid;
      logic [11:0] pixCnt;
      logic [11:0] lineWidth;
      logic [11:0] lineCnt;
      logic [11:0] lineTotal;
      logic        field2;
      logic [11:0] hsSinceCnt;
      logic [12:0] genCnt;
      logic [11:0] genLine;
      logic        genField2;
      logic        dvPrev;
   } state_t;
   state_t q;
   state_t d;

   logic clkLv, clkRise, clkFall;
   logic hsLv, hsRise, hsFall;
   logic vsLv, vsRise, vsFall;
   logic dvLv;
   logic [23:0] pixSync1, pixSync2;
   logic captureEdge;
   logic rangeOk;

   // Pixel clock and sync pins are sampled, not used as clocks
   edge_sync u_clk (.clk(ref_clk), .rstn(rstn), .din(pixelInputClock),
                    .level(clkLv), .rise(clkRise), .fall(clkFall));
   edge_sync u_hs  (.clk(ref_clk), .rstn(rstn), .din(hsyncIn),
                    .level(hsLv), .rise(hsRise), .fall(hsFall));
   edge_sync u_vs  (.clk(ref_clk), .rstn(rstn), .din(vsyncIn),
                    .level(vsLv), .rise(vsRise), .fall(vsFall));
   edge_sync u_dv  (.clk(ref_clk), .rstn(rstn), .din(dataValidStrobe),
                    .level(dvLv), .rise(), .fall());

   // Bus is two stages behind the pins, so it settles before the clock edge is seen
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pixSync1 <= 24'h00_0000;
         pixSync2 <= 24'h00_0000;
      end else begin
         pixSync1 <= pixelData;
         pixSync2 <= pixSync1;
      end
   end

   function automatic logic [31:0] word_read(input state_t s, input logic [7:0] a,
                                             input logic hs, input logic vs);
      case (a)
         tv_input_pkg::CTRL_OFS:    word_read = s.ctrl;
         tv_input_pkg::REFCLK_OFS:  word_read = {24'h00_0000, s.refDiv};
         tv_input_pkg::STATUS_OFS:  word_read = {26'h000_0000, vs, hs, s.field2,
                                                 s.genField2, s.dvPrev, 1'b0};
         tv_input_pkg::WIDTH_OFS:   word_read = {4'h0, s.lineTotal, 4'h0, s.lineWidth};
         tv_input_pkg::PIXEL_OFS:   word_read = {8'h00, s.pixel};
         tv_input_pkg::SYNCGEN_OFS: word_read = {20'h0_0000, s.hsyncW};
         default:                   word_read = 32'h0000_0000;
      endcase
   endfunction

   // Mux at 1X uses both edges; otherwise one edge, chosen by polarity
   always_comb begin
      if (q.ctrl[tv_input_pkg::MUX_BIT] && !q.ctrl[tv_input_pkg::CLK2X_BIT]) begin
         captureEdge = clkRise | clkFall;
      end else if (q.ctrl[tv_input_pkg::CLK_INV_BIT]) begin
         captureEdge = clkFall;
      end else begin
         captureEdge = clkRise;
      end
   end

   assign rangeOk = (q.lineWidth >= tv_input_pkg::MIN_WIDTH) &&
                    (q.lineWidth <= tv_input_pkg::MAX_WIDTH) &&
                    (q.lineTotal >= tv_input_pkg::MIN_LINES) &&
                    (q.lineTotal <= tv_input_pkg::MAX_LINES);

   // Next-state logic: bus slave, capture, field detect, sync and clock generators
   always_comb begin
      d          = q;
      d.pixValid = 1'b0;
      d.dvPrev   = dvLv;
      // AHB-Lite: address phase captured, data phase completes with zero wait states
      if (q.aPend && q.aWrite) begin
         case (q.aAddr)
            tv_input_pkg::CTRL_OFS:    d.ctrl   = hwdata;
            tv_input_pkg::REFCLK_OFS:  d.refDiv = hwdata[7:0];
            tv_input_pkg::SYNCGEN_OFS: d.hsyncW = (hwdata[11:0] == 12'h000) ?
                                                  12'h001 : hwdata[11:0];
            default: ;
         endcase
      end
      d.aPend  = hsel && hready && htrans[1];
      d.aWrite = hwrite;
      d.aAddr  = haddr[7:0];
      // Only strobe-high samples are kept and counted
      if (captureEdge && dvLv) begin
         d.pixel    = pixSync2;
         d.pixValid = 1'b1;
         d.pixCnt   = q.pixCnt + 12'h001;
      end
      if (q.dvPrev && !dvLv) begin
         d.lineWidth = q.pixCnt;
         d.pixCnt    = 12'h000;
         d.lineCnt   = q.lineCnt + 12'h001;
      end
      // Count time since hsync leading edge; vsync arrival time decides the field
      if (hsRise) begin
         d.hsSinceCnt = 12'h000;
      end else if (q.hsSinceCnt != 12'hFFF) begin
         d.hsSinceCnt = q.hsSinceCnt + 12'h001;
      end
      if (vsRise) begin
         d.field2    = (q.hsSinceCnt > q.hsyncW) && !hsRise;
         d.lineTotal = q.lineCnt;
         d.lineCnt   = 12'h000;
      end
      // Sync generator on the system clock, one 63.5 us line per wrap
      if (q.genCnt == 13'(tv_input_pkg::LINE_CYC - 1)) begin
         d.genCnt = 13'h0000;
         if (q.genLine == tv_input_pkg::LINES_PER_FIELD - 12'h001) begin
            d.genLine   = 12'h000;
            d.genField2 = ~q.genField2;
         end else begin
            d.genLine = q.genLine + 12'h001;
         end
      end else begin
         d.genCnt = q.genCnt + 13'h0001;
      end
      // Reference clock divider; half period refDiv cycles
      if (q.divCnt >= q.refDiv - 8'h01 || q.refDiv == 8'h00) begin
         d.divCnt = 8'h00;
         d.refClk = ~q.refClk;
      end else begin
         d.divCnt = q.divCnt + 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         q        <= '0;
         q.ctrl   <= tv_input_pkg::CTRL_RESET;
         q.refDiv <= tv_input_pkg::REFDIV_RESET;
         q.hsyncW <= tv_input_pkg::HSYNC_W_RESET;
      end else begin
         q <= d;
      end
   end

   // Bus answers, zero wait states
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = word_read(q, q.aAddr, hsLv, vsLv);

   // Strap chooses the serial address
   assign serialAddress = busAddressSelect ? tv_input_pkg::ADDR_HIGH
                                           : tv_input_pkg::ADDR_LOW;
   // Pin reset dominates; soft reset bit only matters when the pin is high
   assign coreResetN = resetPinN && !q.ctrl[tv_input_pkg::SOFT_RESET_BIT];

   // Sync pins driven only when direction bit is set
   assign hsyncOe  = q.ctrl[tv_input_pkg::SYNC_DIR_BIT];
   assign vsyncOe  = q.ctrl[tv_input_pkg::SYNC_DIR_BIT];
   assign hsyncOut = hsyncOe && (q.genCnt < 13'(q.hsyncW));
   // Field 2 vsync starts half a line later than hsync
   assign vsyncOut = vsyncOe && (q.genLine < tv_input_pkg::VSYNC_LINES) &&
                     (!q.genField2 || q.genCnt >= 13'(tv_input_pkg::HALF_LINE_CYC));

   // Reference clock: master mode and not tri-stated
   assign refClockOe  = q.ctrl[tv_input_pkg::MASTER_BIT] &&
                        !q.ctrl[tv_input_pkg::REFCLK_HIZ_BIT];
   assign refClockOut = refClockOe && q.refClk;
   // Secondary DAC off in single composite mode
   assign secondaryVideoEn = !q.ctrl[tv_input_pkg::SINGLE_CVBS_BIT];
   // Interlaced input skips the scaler; non-interlaced needs a legal size
   assign bypassScaler  = q.ctrl[tv_input_pkg::INTERLACE_BIT] || !rangeOk;
   assign capturedPixel = q.pixel;
   assign pixelValid    = q.pixValid;
   assign fieldTwo      = q.field2;

   a_sync_drive: assert property (@(posedge ref_clk) disable iff (!rstn)
      !q.ctrl[tv_input_pkg::SYNC_DIR_BIT] |-> !hsyncOe && !vsyncOe)
      else $error("sync pins driven in input mode");
   a_blank_ignored: assert property (@(posedge ref_clk) disable iff (!rstn)
      !dvLv |=> !pixelValid)
      else $error("pixel captured during blanking");
   a_addr_select: assert property (@(posedge ref_clk) disable iff (!rstn)
      serialAddress == (busAddressSelect ? 7'h75 : 7'h76))
      else $error("wrong serial address");
   a_pin_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
      !resetPinN |-> !coreResetN)
      else $error("core left reset while pin low");
   a_single_cvbs: assert property (@(posedge ref_clk) disable iff (!rstn)
      q.ctrl[tv_input_pkg::SINGLE_CVBS_BIT] |-> !secondaryVideoEn)
      else $error("secondary output on in single mode");
   a_refclk_off: assert property (@(posedge ref_clk) disable iff (!rstn)
      (!q.ctrl[tv_input_pkg::MASTER_BIT] || q.ctrl[tv_input_pkg::REFCLK_HIZ_BIT])
      |-> !refClockOe && !refClockOut)
      else $error("reference clock out in slave or hi-z");
   a_refclk_toggle: assert property (@(posedge ref_clk) disable iff (!rstn)
      refClockOe && q.refDiv == 8'h01 |=> refClockOe == 1'b0 || refClockOut != $past(refClockOut))
      else $error("reference clock divider stalled");
   a_field1_align: assert property (@(posedge ref_clk) disable iff (!rstn)
      vsyncOe && $rose(vsyncOut) && !q.genField2 |-> hsyncOut)
      else $error("field 1 vsync not aligned to hsync");
   a_bypass_ilace: assert property (@(posedge ref_clk) disable iff (!rstn)
      q.ctrl[tv_input_pkg::INTERLACE_BIT] |-> bypassScaler)
      else $error("interlaced input went through scaler");
   a_ddr_capture: assert property (@(posedge ref_clk) disable iff (!rstn)
      q.ctrl[tv_input_pkg::MUX_BIT] && !q.ctrl[tv_input_pkg::CLK2X_BIT] && clkFall && dvLv
      |=> pixelValid)
      else $error("falling edge missed in dual edge mode");
endmodule

// file: dv/pixel_source.sv
// Behavioural graphics controller port driving clock, pixel bus, strobe and syncs.
// Assumes the device samples every pin with its own system clock.
module pixel_source (
   output logic        pclk,   // Pixel clock, still outside frames
   output logic [23:0] data,   // Pixel bus
   output logic        dv,     // Active-video strobe
   output logic        hs,     // Horizontal sync
   output logic        vs      // Vertical sync
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle levels at time zero
   initial begin
      pclk = 1'b0;
      data = 24'h000000;
      dv   = 1'b0;
      hs   = 1'b0;
      vs   = 1'b0;
   end

   // Pixels at 1X, 200 ns; pins move 10 ns off the system clock edges, but the final release lands on a rising edge and races the sample.
   // Strobe leads the first clock edge and trails the last one by several system cycles.
   task automatic pixels(input int n, input logic valid, input logic [23:0] base);
      #10 dv = valid;
      for (int i = 0; i < n; i++) begin
         #75 data = base + 24'(i);
         #25 pclk = 1'b1;
         #75 data = ~(base + 24'(i)); // Second half for dual edge capture
         #25 pclk = 1'b0;
      end
      #90 data = ~data; // Released bus must not keep its last value
      dv = 1'b0;
   endtask

   // Separate sync pins: 1600 ns hsync, vsync at the given delay after it
   task automatic line_sync(input logic withVs, input int vsDelay);
      hs = 1'b1;
      if (withVs && vsDelay == 0) vs = 1'b1;
      #1600 hs = 1'b0;
      if (withVs && vsDelay > 0) #(vsDelay - 1600) vs = 1'b1;
      #2000 vs = 1'b0;
   endtask
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the TV encoder video input front end.
// Assumes the AHB-Lite slave answers with hreadyout and a pixel source on the pins.
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin badCount++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0, rstn = 1'b0, resetPinN = 1'b1, busAddressSelect = 1'b0;
   logic        hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, pclk, dv, srcHs, srcVs;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]  htrans = 2'h0;
   logic [23:0] pdata, capturedPixel;
   logic [6:0]  serialAddress;
   logic        hsyncOut, hsyncOe, vsyncOut, vsyncOe, refClockOut, refClockOe;
   logic        secondaryVideoEn, pixelValid, bypassScaler, fieldTwo, coreResetN;
   int          badCount = 0, compares = 0, cycles = 0, pulses = 0, n;
   logic [31:0] ctrlTab [6] = '{32'h000, 32'h001, 32'h002, 32'h006, 32'h080, 32'h100};
   logic [5:0]  expTab  [6] = '{6'h07, 6'h37, 6'h0F, 6'h07, 6'h03, 6'h06};
   logic [31:0] modeTab [4] = '{32'h00, 32'h08, 32'h18, 32'h20};
   int          multTab [4] = '{1, 2, 1, 1};
   // Sync pins resolve to the device when it drives, else to the source
   wire         hsPin = hsyncOe ? hsyncOut : srcHs;
   wire         vsPin = vsyncOe ? vsyncOut : srcVs;

   tv_video_input dut (.ref_clk(ref_clk), .rstn(rstn), .resetPinN(resetPinN),
      .busAddressSelect(busAddressSelect), .serialAddress(serialAddress), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pixelInputClock(pclk), .pixelData(pdata), .dataValidStrobe(dv), .hsyncIn(hsPin),
      .hsyncOut(hsyncOut), .hsyncOe(hsyncOe), .vsyncIn(vsPin), .vsyncOut(vsyncOut),
      .vsyncOe(vsyncOe), .refClockOut(refClockOut), .refClockOe(refClockOe),
      .secondaryVideoEn(secondaryVideoEn), .capturedPixel(capturedPixel),
      .pixelValid(pixelValid), .bypassScaler(bypassScaler), .fieldTwo(fieldTwo),
      .coreResetN(coreResetN));
   pixel_source src (.pclk(pclk), .data(pdata), .dv(dv), .hs(srcHs), .vs(srcVs));

   // 40 MHz system clock
   always #12.5 ref_clk = ~ref_clk;

   // Capture pulse counter and hang guard, sized well above the planned run
   always @(posedge ref_clk) begin
      cycles++;
      if (pixelValid === 1'b1) pulses++;
      if (cycles == 60000) begin
         badCount++;
         stopTest();
      end
   end

   task automatic stopTest();
      $display("Mismatches %0d, comparisons %0d", badCount, compares);
      if (badCount == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // One single AHB-Lite transfer; read data taken at the edge closing the data phase
   task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, adr};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      hsel <= 1'b0;
   endtask

   // Reference clock period in system cycles, rise to rise
   task automatic period(output int cnt);
      cnt = 0;
      do @(posedge ref_clk); while (refClockOut !== 1'b0);
      do @(posedge ref_clk); while (refClockOut !== 1'b1);
      do begin @(posedge ref_clk); cnt++; end while (refClockOut !== 1'b0);
      do begin @(posedge ref_clk); cnt++; end while (refClockOut !== 1'b1);
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      `CHK(hresp, 1'b0)
      bus(1'b0, tv_input_pkg::CTRL_OFS, 32'h0);
      `CHK(rd, tv_input_pkg::CTRL_RESET)
      bus(1'b0, tv_input_pkg::REFCLK_OFS, 32'h0);
      `CHK(rd, {24'h000000, tv_input_pkg::REFDIV_RESET})
      bus(1'b0, tv_input_pkg::SYNCGEN_OFS, 32'h0);
      `CHK(rd, {20'h00000, tv_input_pkg::HSYNC_W_RESET})
      bus(1'b1, 8'h40, 32'hFFFFFFFF);
      bus(1'b0, 8'h40, 32'h0);
      `CHK(rd, 32'h00000000)
      bus(1'b1, tv_input_pkg::SYNCGEN_OFS, 32'h0);
      bus(1'b0, tv_input_pkg::SYNCGEN_OFS, 32'h0);
      `CHK(rd, 32'h00000001)
      bus(1'b1, tv_input_pkg::SYNCGEN_OFS, {20'h00000, tv_input_pkg::HSYNC_W_RESET});
      // Address strap both ways, reset pin low then high
      busAddressSelect <= 1'b1;
      resetPinN <= 1'b0;
      #1 `CHK(serialAddress, tv_input_pkg::ADDR_HIGH)
      `CHK(coreResetN, 1'b0)
      busAddressSelect <= 1'b0;
      resetPinN <= 1'b1;
      #1 `CHK(serialAddress, tv_input_pkg::ADDR_LOW)
      // Control bits against pin enables and power controls
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, tv_input_pkg::CTRL_OFS, ctrlTab[i]);
         repeat (2) @(posedge ref_clk);
         `CHK({hsyncOe, vsyncOe, refClockOe, secondaryVideoEn, bypassScaler, coreResetN}, expTab[i])
      end
      // Reference clock rate from the divider, reset value 4 then 3, 2 and 1
      bus(1'b1, tv_input_pkg::CTRL_OFS, 32'h002);
      for (int d = 4; d >= 1; d--) begin
         bus(1'b1, tv_input_pkg::REFCLK_OFS, 32'(d));
         period(n);
         `CHK(n, 2 * d)
      end
      // Transfer modes: pulse count and last captured word, blanking ignored
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, tv_input_pkg::CTRL_OFS, modeTab[m]);
         pulses = 0;
         src.pixels(3, 1'b0, 24'h5A0000);
         src.pixels(6, 1'b1, 24'h123450);
         src.pixels(2, 1'b0, 24'h0F0F00);
         repeat (10) @(posedge ref_clk);
         `CHK(pulses, 6 * multTab[m])
         `CHK(capturedPixel, (m % 2) ? 24'hEDCBAA : 24'h123455)
      end
      // Active width counted over each strobe-high run, blanking excluded
      bus(1'b1, tv_input_pkg::CTRL_OFS, 32'h000);
      repeat (2) begin
         src.line_sync(1'b0, 0);
         src.pixels(3, 1'b0, 24'h777700);
         src.pixels(10, 1'b1, 24'h010200);
         src.pixels(3, 1'b0, 24'h333300);
      end
      src.line_sync(1'b0, 0);
      bus(1'b0, tv_input_pkg::WIDTH_OFS, 32'h0);
      `CHK(rd[11:0], 12'h00A)
      // Field identity from vsync offset: half line, then aligned
      for (int f = 1; f >= 0; f--) begin
         src.line_sync(1'b1, f * 31750);
         repeat (20) @(posedge ref_clk);
         `CHK(fieldTwo, f[0])
      end
      stopTest();
   end
endmodule
